// ---- soft_pin_pkg.sv ----
package soft_pin_pkg;
    // ----------------------------------------
    // Register map
    // ----------------------------------------
    localparam logic [11:0] ADDR_OUT_SCALE   = 12'hc05;
    localparam logic [11:0] ADDR_LOOP_TOL    = 12'hc06;
    localparam logic [11:0] ADDR_XFER_TRIG   = 12'hc07;
    localparam logic [11:0] ADDR_RESET_DL    = 12'hc08;
    localparam logic [11:0] ADDR_NVM_STATUS  = 12'hd00;
    localparam logic [11:0] ADDR_UPDATE      = 12'h005;
    localparam logic [11:0] ADDR_SECT_EN     = 12'hc03;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'he00;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'he01;
    // ----------------------------------------
    // Fields and reset values
    // ----------------------------------------
    localparam logic [7:0]  OUT_SCALE_MASK   = 8'h0f;
    localparam logic [7:0]  LOOP_TOL_MASK    = 8'h1f;
    localparam logic [7:0]  UPDATE_CODE      = 8'h01;
    localparam logic [7:0]  OUT_SCALE_RST    = 8'h00;
    localparam logic [7:0]  LOOP_TOL_RST     = 8'h00;
    localparam int          ROM_BIT          = 3;
    localparam int          FAULT_BIT        = 2;
    localparam int          LOAD_BIT         = 1;
    localparam int          SAVE_BIT         = 0;
    localparam logic [1:0]  IRQ_ROM_DONE     = 2'h1;
    localparam logic [1:0]  IRQ_NVM_FAULT    = 2'h2;
    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int          ROM_LOAD_NS      = 1000;
    localparam int          CLK_NS           = 10;
    localparam int          ROM_LOAD_CYC     = (ROM_LOAD_NS + CLK_NS - 1) / CLK_NS;

    typedef struct packed {
        logic [1:0] ch1_div;
        logic [1:0] ch0_div;
        logic       high_pm;
        logic [1:0] loop_bw;
        logic [1:0] ref_tol;
    } soft_cfg_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } reg_req_t;
endpackage

// ---- soft_pin_config_loader.sv ----
// Notes on behaviour
// RULE_01 - Channel 1 divide code in bits 3:2
// RULE_02 - Channel 0 divide code in bits 1:0
// RULE_03 - Bit 4 picks high phase margin filter
// RULE_04 - Loop bandwidth code, default 50 Hz
// RULE_05 - Reference tolerance code, default 10%/8%
// RULE_06 - Start bit loads ROM, clears when done
// RULE_07 - Reset bit resets core, loads, self-clears
// RULE_08 - Staged values apply only after trigger
// RULE_09 - Status read-only, refreshed by update write
// RULE_10 - Status bit 3 high during ROM fetch
// RULE_11 - Status bit 2 on nonvolatile fault
// RULE_12 - Status bit 1 during EEPROM load
// RULE_13 - Status bit 0 during EEPROM save
// RULE_14 - Soft section needs enable and pin low
// RULE_15 - Reserved bits ignore writes, read zero
module soft_pin_config_loader
    import soft_pin_pkg::*;
#(
    parameter int ROM_CYC = ROM_LOAD_CYC
) (
    input  wire logic                    ref_clk,
    input  wire logic                    rst,
    input  wire soft_pin_pkg::reg_req_t  req,
    output logic [7:0]                   rdata,
    input  wire logic                    pin_strap_select,
    input  wire logic                    nvm_load_busy,
    input  wire logic                    nvm_save_busy,
    input  wire logic                    nvm_fault,
    output soft_pin_pkg::soft_cfg_t      active_cfg,
    output logic                         core_soft_reset,
    output logic                         rom_fetch,
    output logic                         irq
);
    import soft_pin_pkg::*;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_LOAD = 2'b10
    } load_state_t;

    // ----------------------------------------
    // Pin and status synchronisers
    // ----------------------------------------
    // Three stages; a change counts when stages two and three agree.
    logic [3:0] sync1_r;
    logic [3:0] sync2_r;
    logic [3:0] sync3_r;
    logic [3:0] filt_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            sync1_r <= 4'h0;
            sync2_r <= 4'h0;
            sync3_r <= 4'h0;
            filt_r  <= 4'h0;
        end else begin
            sync1_r <= {pin_strap_select, nvm_load_busy, nvm_save_busy, nvm_fault};
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r  <= (sync2_r & sync3_r) | (filt_r & (sync2_r | sync3_r));
        end
    end
    wire pin_low   = ~filt_r[3];
    wire load_busy = filt_r[2];
    wire save_busy = filt_r[1];
    wire fault_in  = filt_r[0];

    // ----------------------------------------
    // Register decode
    // ----------------------------------------
    wire wr_out   = req.wr && (req.addr == ADDR_OUT_SCALE);
    wire wr_loop  = req.wr && (req.addr == ADDR_LOOP_TOL);
    wire wr_xfer  = req.wr && (req.addr == ADDR_XFER_TRIG) && req.wdata[0];
    wire wr_rdl   = req.wr && (req.addr == ADDR_RESET_DL) && req.wdata[0];
    wire wr_upd   = req.wr && (req.addr == ADDR_UPDATE) && (req.wdata == UPDATE_CODE);
    wire wr_en    = req.wr && (req.addr == ADDR_SECT_EN);
    wire wr_istat = req.wr && (req.addr == ADDR_IRQ_STATUS);
    wire wr_imask = req.wr && (req.addr == ADDR_IRQ_MASK);

    logic [7:0]  out_scale_r;
    logic [7:0]  loop_tol_r;
    logic        sect_en_r;
    logic        xfer_r;
    logic        rdl_r;
    logic [7:0]  status_r;
    logic [1:0]  irq_stat_r;
    logic [1:0]  irq_mask_r;
    logic [7:0]  rdata_r;
    soft_cfg_t   cfg_r;
    logic        core_rst_r;
    load_state_t state_r;
    load_state_t state_nxt;
    logic [15:0] cnt_r;

    // Staging registers; reserved bits masked off on write
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_scale_r <= OUT_SCALE_RST;
            loop_tol_r  <= LOOP_TOL_RST;
            sect_en_r   <= 1'b0;
        end else begin
            if (wr_out)
                out_scale_r <= req.wdata & OUT_SCALE_MASK; // [RULE_15]
            if (wr_loop)
                loop_tol_r <= req.wdata & LOOP_TOL_MASK; // [RULE_15]
            if (wr_en)
                sect_en_r <= req.wdata[0];
        end
    end

    // ----------------------------------------
    // Download sequencer
    // ----------------------------------------
    wire load_done = (state_r == ST_LOAD) && (cnt_r == 16'(ROM_CYC - 1));
    wire sect_live = sect_en_r && pin_low; // [RULE_14]

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: if (wr_xfer || wr_rdl) state_nxt = ST_LOAD;
            ST_LOAD: if (load_done) state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r    <= ST_IDLE;
            cnt_r      <= 16'h0;
            xfer_r     <= 1'b0;
            rdl_r      <= 1'b0;
            core_rst_r <= 1'b0;
        end else begin
            state_r    <= state_nxt;
            cnt_r      <= (state_r == ST_LOAD) ? cnt_r + 16'h1 : 16'h0;
            if (state_r == ST_IDLE && wr_xfer)
                xfer_r <= 1'b1; // [RULE_06]
            else if (load_done)
                xfer_r <= 1'b0; // [RULE_06]
            if (state_r == ST_IDLE && wr_rdl)
                rdl_r <= 1'b1; // [RULE_07]
            else if (load_done)
                rdl_r <= 1'b0; // [RULE_07]
            // One-cycle core reset pulse; register map untouched
            core_rst_r <= (state_r == ST_IDLE) && wr_rdl; // [RULE_07]
        end
    end

    // Applied settings move only at end of a download
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cfg_r <= '0;
        end else if (load_done && sect_live) begin
            cfg_r.ch1_div <= out_scale_r[3:2]; // [RULE_01] [RULE_08]
            cfg_r.ch0_div <= out_scale_r[1:0]; // [RULE_02] [RULE_08]
            cfg_r.high_pm <= loop_tol_r[4];    // [RULE_03]
            cfg_r.loop_bw <= loop_tol_r[3:2];  // [RULE_04]
            cfg_r.ref_tol <= loop_tol_r[1:0];  // [RULE_05]
        end
    end

    // ----------------------------------------
    // Status snapshot and interrupts
    // ----------------------------------------
    wire [7:0] live_status = {4'h0, (state_r == ST_LOAD), fault_in, load_busy, save_busy};
    wire [1:0] irq_evt = {fault_in & ~status_r[FAULT_BIT] & wr_upd, load_done};

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            status_r   <= 8'h00;
            irq_stat_r <= 2'h0;
            irq_mask_r <= 2'h0;
        end else begin
            if (wr_upd)
                status_r <= live_status; // [RULE_09] [RULE_10] [RULE_11] [RULE_12] [RULE_13]
            // Set wins over write-one-to-clear
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? req.wdata[1:0] : 2'h0)) | irq_evt;
            if (wr_imask)
                irq_mask_r <= req.wdata[1:0];
        end
    end

    // Read mux; unmapped and reserved read zero
    wire [7:0] rd_mux =
        (req.addr == ADDR_OUT_SCALE)  ? out_scale_r :
        (req.addr == ADDR_LOOP_TOL)   ? loop_tol_r :
        (req.addr == ADDR_XFER_TRIG)  ? {7'h0, xfer_r} :
        (req.addr == ADDR_RESET_DL)   ? {7'h0, rdl_r} :
        (req.addr == ADDR_NVM_STATUS) ? status_r :
        (req.addr == ADDR_SECT_EN)    ? {7'h0, sect_en_r} :
        (req.addr == ADDR_IRQ_STATUS) ? {6'h0, irq_stat_r} :
        (req.addr == ADDR_IRQ_MASK)   ? {6'h0, irq_mask_r} : 8'h00; // [RULE_15]

    logic irq_r;
    logic rom_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
            irq_r   <= 1'b0;
            rom_r   <= 1'b0;
        end else begin
            rdata_r <= req.rd ? rd_mux : 8'h00;
            irq_r   <= |(irq_stat_r & irq_mask_r);
            rom_r   <= (state_nxt == ST_LOAD);
        end
    end

    assign rdata           = rdata_r;
    assign active_cfg      = cfg_r;
    assign core_soft_reset = core_rst_r;
    assign rom_fetch       = rom_r;
    assign irq             = irq_r;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    property p_xfer_clear;
        @(posedge ref_clk) disable iff (rst)
        load_done |=> !xfer_r && !rdl_r;
    endproperty
    a_xfer_clear: assert property (p_xfer_clear) else $error("trigger not cleared"); // [RULE_06]

    property p_xfer_set;
        @(posedge ref_clk) disable iff (rst)
        (state_r == ST_IDLE && wr_xfer) |=> xfer_r && state_r == ST_LOAD;
    endproperty
    a_xfer_set: assert property (p_xfer_set) else $error("start not taken"); // [RULE_06]

    property p_rdl_pulse;
        @(posedge ref_clk) disable iff (rst)
        core_rst_r |=> !core_rst_r && rdl_r;
    endproperty
    a_rdl_pulse: assert property (p_rdl_pulse) else $error("reset pulse wrong"); // [RULE_07]

    property p_cfg_hold;
        @(posedge ref_clk) disable iff (rst)
        !load_done |=> $stable(cfg_r);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("config moved early"); // [RULE_08]

    property p_cfg_apply;
        @(posedge ref_clk) disable iff (rst)
        (load_done && sect_live) |=> cfg_r.ch0_div == $past(out_scale_r[1:0])
            && cfg_r.ch1_div == $past(out_scale_r[3:2]) && cfg_r.loop_bw == $past(loop_tol_r[3:2]);
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("config not applied"); // [RULE_01]

    property p_section_off;
        @(posedge ref_clk) disable iff (rst)
        (load_done && !sect_live) |=> $stable(cfg_r);
    endproperty
    a_section_off: assert property (p_section_off) else $error("disabled section applied"); // [RULE_14]

    property p_status_hold;
        @(posedge ref_clk) disable iff (rst)
        !wr_upd |=> $stable(status_r);
    endproperty
    a_status_hold: assert property (p_status_hold) else $error("status moved"); // [RULE_09]

    property p_rom_bit;
        @(posedge ref_clk) disable iff (rst)
        wr_upd |=> status_r[ROM_BIT] == ($past(state_r) == ST_LOAD);
    endproperty
    a_rom_bit: assert property (p_rom_bit) else $error("rom bit wrong"); // [RULE_10]

    property p_nvm_bits;
        @(posedge ref_clk) disable iff (rst)
        wr_upd |=> status_r[2:0] == {$past(fault_in), $past(load_busy), $past(save_busy)};
    endproperty
    a_nvm_bits: assert property (p_nvm_bits) else $error("nvm bits wrong"); // [RULE_11] [RULE_12] [RULE_13]

    property p_reserved;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |-> out_scale_r[7:4] == 4'h0 && loop_tol_r[7:5] == 3'h0 && status_r[7:4] == 4'h0;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set"); // [RULE_15]

    property p_rom_out;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |-> rom_r == (state_r == ST_LOAD);
    endproperty
    a_rom_out: assert property (p_rom_out) else $error("fetch flag wrong"); // [RULE_10]

    property p_cnt_bound;
        @(posedge ref_clk) disable iff (rst)
        (state_r == ST_LOAD) |-> cnt_r < 16'(ROM_CYC);
    endproperty
    a_cnt_bound: assert property (p_cnt_bound) else $error("download overran"); // [RULE_06]

    property p_rdata_idle;
        @(posedge ref_clk) disable iff (rst)
        !req.rd |=> rdata_r == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("rdata not idle"); // [RULE_09]

    property p_status_read;
        @(posedge ref_clk) disable iff (rst)
        (req.rd && req.addr == ADDR_NVM_STATUS) |=> rdata_r == $past(status_r);
    endproperty
    a_status_read: assert property (p_status_read) else $error("bad status read"); // [RULE_09]

    property p_retrig;
        @(posedge ref_clk) disable iff (rst)
        (state_r == ST_LOAD && (wr_xfer || wr_rdl)) |=> !core_rst_r;
    endproperty
    a_retrig: assert property (p_retrig) else $error("retrigger taken"); // [RULE_07]

    property p_rdl_set;
        @(posedge ref_clk) disable iff (rst)
        (state_r == ST_IDLE && wr_rdl) |=> rdl_r && core_rst_r && state_r == ST_LOAD;
    endproperty
    a_rdl_set: assert property (p_rdl_set) else $error("reset trigger lost"); // [RULE_07]

    property p_irq_level;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |=> irq_r == (($past(irq_stat_r) & $past(irq_mask_r)) != 2'h0);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("bad irq"); // [RULE_06] [RULE_11]

    property p_done_evt;
        @(posedge ref_clk) disable iff (rst)
        load_done |=> irq_stat_r[0];
    endproperty
    a_done_evt: assert property (p_done_evt) else $error("done event lost"); // [RULE_06]

    property p_sticky;
        @(posedge ref_clk) disable iff (rst)
        !wr_istat |=> (irq_stat_r & $past(irq_stat_r)) == $past(irq_stat_r);
    endproperty
    a_sticky: assert property (p_sticky) else $error("event bit dropped"); // [RULE_11]

    property p_fault_evt;
        @(posedge ref_clk) disable iff (rst)
        (wr_upd && fault_in && !status_r[FAULT_BIT]) |=> irq_stat_r[1];
    endproperty
    a_fault_evt: assert property (p_fault_evt) else $error("fault event lost"); // [RULE_11]

    property p_onehot;
        @(posedge ref_clk) disable iff (rst)
        1'b1 |-> $onehot(state_r);
    endproperty
    a_onehot: assert property (p_onehot) else $error("state not one-hot"); // [RULE_06]

    property p_rst_src;
        @(posedge ref_clk) disable iff (rst)
        core_rst_r |-> $past(wr_rdl) && $past(state_r) == ST_IDLE;
    endproperty
    a_rst_src: assert property (p_rst_src) else $error("stray core reset"); // [RULE_07]

    property p_trig_busy;
        @(posedge ref_clk) disable iff (rst)
        (xfer_r || rdl_r) |-> state_r == ST_LOAD;
    endproperty
    a_trig_busy: assert property (p_trig_busy) else $error("stale trigger"); // [RULE_06]

    property p_stage_hold;
        @(posedge ref_clk) disable iff (rst)
        !wr_out |=> $stable(out_scale_r);
    endproperty
    a_stage_hold: assert property (p_stage_hold) else $error("staging moved"); // [RULE_08]

    property p_filter;
        @(posedge ref_clk) disable iff (rst)
        (sync2_r[3] != sync3_r[3]) |=> $stable(filt_r[3]);
    endproperty
    a_filter: assert property (p_filter) else $error("pin glitch passed"); // [RULE_14]

    property p_cfg_loop;
        @(posedge ref_clk) disable iff (rst)
        (load_done && sect_live) |=> cfg_r.high_pm == $past(loop_tol_r[4])
            && cfg_r.ref_tol == $past(loop_tol_r[1:0]);
    endproperty
    a_cfg_loop: assert property (p_cfg_loop) else $error("loop setting lost"); // [RULE_03] [RULE_05]

    c_download:  cover property (@(posedge ref_clk) disable iff (rst) load_done && sect_live);
    c_reset_dl:  cover property (@(posedge ref_clk) disable iff (rst) core_rst_r);
    c_irq:       cover property (@(posedge ref_clk) disable iff (rst) irq_r);
    c_fault_irq: cover property (@(posedge ref_clk) disable iff (rst) irq_stat_r[1]);
    c_retrig:    cover property (@(posedge ref_clk) disable iff (rst) wr_rdl && xfer_r);
endmodule // soft_pin_config_loader

// ---- tb.sv ----
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import soft_pin_pkg::*;

    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic       ref_clk          = 1'b0;
    logic       rst              = 1'b1;
    logic       pin_strap_select = 1'b0;
    logic       nvm_load_busy    = 1'b0;
    logic       nvm_save_busy    = 1'b0;
    logic       nvm_fault        = 1'b0;
    reg_req_t   req              = '0;
    logic [7:0] rdata;
    soft_cfg_t  active_cfg;
    logic       core_soft_reset;
    logic       rom_fetch;
    logic       irq;
    int         num_errors       = 0;
    int         check_count      = 0;
    int         pulses           = 0;

    typedef struct packed {
        logic [11:0] a;
        logic [7:0]  d;
        logic [7:0]  e;
    } row_t;
    // Reserved bits, read-only and unmapped places among the rows
    row_t rows [9] = '{'{12'hc05, 8'hff, 8'h0f}, '{12'hc06, 8'hff, 8'h1f},
                       '{12'hd00, 8'hff, 8'h00}, '{12'h123, 8'h5a, 8'h00},
                       '{12'hc07, 8'hfe, 8'h00}, '{12'hc08, 8'hfe, 8'h00},
                       '{12'hc05, 8'h0d, 8'h0d}, '{12'hc06, 8'h1b, 8'h1b},
                       '{12'hc03, 8'hff, 8'h01}};

    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (core_soft_reset === 1'b1) pulses++;

    soft_pin_config_loader #(.ROM_CYC(8)) i_soft_pin_config_loader (
        .ref_clk          (ref_clk),
        .rst              (rst),
        .req              (req),
        .rdata            (rdata),
        .pin_strap_select (pin_strap_select),
        .nvm_load_busy    (nvm_load_busy),
        .nvm_save_busy    (nvm_save_busy),
        .nvm_fault        (nvm_fault),
        .active_cfg       (active_cfg),
        .core_soft_reset  (core_soft_reset),
        .rom_fetch        (rom_fetch),
        .irq              (irq)
    );

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic finish_test();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req.wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1;
        check(16'(rdata), 16'(e));
    endtask

    // Bounded wait on the fetch flag (0) or the interrupt (1)
    task automatic wait_for(input int which, input logic v);
        int n;
        n = 0;
        #1;
        while (((which == 0) ? rom_fetch : irq) !== v && n < 50) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        check_count++;
        if (n == 50) begin
            num_errors++;
            $display("mismatch at %0t: wait got %h expected %h", $time, !v, v);
            finish_test();
        end
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (4) @(posedge ref_clk);
        check(16'(active_cfg), 16'h0000);
        check(16'(irq), 16'h0000);
        rd_chk(ADDR_OUT_SCALE, OUT_SCALE_RST);
        rd_chk(ADDR_LOOP_TOL, LOOP_TOL_RST);
        foreach (rows[i]) begin
            reg_wr(rows[i].a, rows[i].d);
            rd_chk(rows[i].a, rows[i].e);
        end
        check(16'(active_cfg), 16'h0000);
        reg_wr(ADDR_XFER_TRIG, 8'h01);
        wait_for(0, 1'b1);
        reg_wr(ADDR_UPDATE, UPDATE_CODE);
        rd_chk(ADDR_XFER_TRIG, 8'h01);
        rd_chk(ADDR_NVM_STATUS, 8'h08);
        wait_for(0, 1'b0);
        check(16'(active_cfg), 16'(9'b11_01_1_10_11));
        rd_chk(ADDR_XFER_TRIG, 8'h00);
        check(16'(pulses), 16'h0000);
        reg_wr(ADDR_UPDATE, UPDATE_CODE);
        rd_chk(ADDR_NVM_STATUS, 8'h00);
        // Interrupt raised by download end, then masked in and cleared
        reg_wr(ADDR_IRQ_MASK, {6'h00, IRQ_ROM_DONE});
        wait_for(1, 1'b1);
        rd_chk(ADDR_IRQ_STATUS, {6'h00, IRQ_ROM_DONE});
        reg_wr(ADDR_IRQ_STATUS, {6'h00, IRQ_ROM_DONE});
        wait_for(1, 1'b0);
        // Pin control takes the soft section away; reset still runs
        @(posedge ref_clk);
        pin_strap_select <= 1'b1;
        repeat (5) @(posedge ref_clk);
        reg_wr(ADDR_OUT_SCALE, 8'h05);
        reg_wr(ADDR_RESET_DL, 8'h01);
        wait_for(0, 1'b1);
        rd_chk(ADDR_RESET_DL, 8'h01);
        wait_for(0, 1'b0);
        check(16'(pulses), 16'h0001);
        check(16'(active_cfg), 16'(9'b11_01_1_10_11));
        rd_chk(ADDR_RESET_DL, 8'h00);
        rd_chk(ADDR_OUT_SCALE, 8'h05);
        @(posedge ref_clk);
        pin_strap_select <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reg_wr(ADDR_XFER_TRIG, 8'h01);
        wait_for(0, 1'b1);
        // A second trigger inside the download is refused
        reg_wr(ADDR_RESET_DL, 8'h01);
        wait_for(0, 1'b0);
        check(16'(active_cfg), 16'(9'b01_01_1_10_11));
        check(16'(pulses), 16'h0001);
        rd_chk(ADDR_RESET_DL, 8'h00);
        // Nonvolatile status bits one at a time
        reg_wr(ADDR_IRQ_MASK, {6'h00, IRQ_NVM_FAULT});
        for (int b = 0; b < 3; b++) begin
            @(posedge ref_clk);
            nvm_save_busy <= (b == 0);
            nvm_load_busy <= (b == 1);
            nvm_fault     <= (b == 2);
            repeat (6) @(posedge ref_clk);
            reg_wr(ADDR_UPDATE, UPDATE_CODE);
            rd_chk(ADDR_NVM_STATUS, 8'h01 << b);
        end
        wait_for(1, 1'b1);
        @(posedge ref_clk);
        nvm_fault <= 1'b0;
        nvm_save_busy <= 1'b1;
        repeat (6) @(posedge ref_clk);
        reg_wr(ADDR_IRQ_STATUS, 8'h03);
        wait_for(1, 1'b0);
        // Wrong update code and a write to status leave the snapshot alone
        reg_wr(ADDR_UPDATE, 8'h02);
        reg_wr(ADDR_NVM_STATUS, 8'hff);
        rd_chk(ADDR_NVM_STATUS, 8'h04);
        reg_wr(ADDR_UPDATE, UPDATE_CODE);
        rd_chk(ADDR_NVM_STATUS, 8'h01);
        // Second reset mid-run
        @(posedge ref_clk);
        rst <= 1'b1;
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        rd_chk(ADDR_OUT_SCALE, 8'h00);
        check(16'(active_cfg), 16'h0000);
        finish_test();
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        num_errors++;
        $display("mismatch at %0t: run limit got %h expected %h", $time, 1'b0, 1'b1);
        finish_test();
    end
endmodule // tb
